// >>> sof_map.svh
// register map, field positions and reset values of the output fault supervisor
// What this block does
// - internal error enters serious error state and clears internal-tests status bit
// - only the internal-error path drives the serious error state
// - overcurrent latch clears once that output's process data bit is zero
// - stuck-high or test-pulse latch clears when all safety data bits zero, sense low
// - high level on an off safety output with no overcurrent latched cuts the module's output supply
// - test or non-safe output overload switches off only while it lasts
// - test or non-safe output faults raise no status or diagnostic
// - capacitive-load transient is treated as an internal error
// - serious error state halts every application
// - serious error state holds every safety output off
// - serious error state forces all process data to zero
// - serious error hides status bits from logic, leaves limited diagnostics
// - serious error persists until power-on restart or software reset
// - overload on an on output switches it off, clears data and short-low bits
// - output high while off and not overcurrent-latched switches all safety outputs off, clears data status
// - test pulses misread clear that output's short-to-high status bit
`ifndef SOF_MAP_SVH
`define SOF_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SOF_OFS_CTRL      8'h00
`define SOF_OFS_PDATA     8'h04
`define SOF_OFS_STATUS    8'h08
`define SOF_OFS_IRQ_STAT  8'h0c
`define SOF_OFS_IRQ_MASK  8'h10
`define SOF_OFS_DIAG      8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SOF_CTRL_SWRST    0
`define SOF_ST_INT_OK     8
`define SOF_ST_SUPPLY_OK  9
`define SOF_ST_ODATA_OK   10
`define SOF_ST_SERIOUS    11
`define SOF_EV_OVC        0
`define SOF_EV_HIGH       1
`define SOF_EV_TPULSE     2
`define SOF_EV_SERIOUS    3
`define SOF_EV_SUPPLY     4

// ----------------------------------------------------------------
// reset values and bus response codes
// ----------------------------------------------------------------
`define SOF_RST_PDATA     8'h00
`define SOF_RST_MASK      5'h00
`define SOF_RESP_OKAY     2'h0
`define SOF_RESP_SLVERR   2'h2

`endif

// >>> sof_pkg.sv
// types shared by the output fault supervisor
package sof_pkg;
   typedef logic [7:0]  sof_addr_t;
   typedef logic [31:0] sof_word_t;
   typedef logic [3:0]  sof_chan_t;
   typedef logic [4:0]  sof_ev_t;
   typedef enum logic [0:0] {
      SOF_RUN     = 1'b0,
      SOF_SERIOUS = 1'b1
   } sof_mode_t;
endpackage

// >>> sof_reg_if.sv
// register access strobes between bus slave and supervisor core
`timescale 1ns/100ps
interface sof_reg_if;
   import sof_pkg::*;
   logic        wr_en;
   sof_addr_t   wr_addr;
   sof_word_t   wr_data;
   logic [3:0]  wr_strb;
   logic        wr_hit;
   sof_addr_t   rd_addr;
   sof_word_t   rd_data;
   logic        rd_hit;
   modport bus  (output wr_en, output wr_addr, output wr_data, output wr_strb,
                 output rd_addr, input wr_hit, input rd_data, input rd_hit);
   modport regs (input wr_en, input wr_addr, input wr_data, input wr_strb,
                 input rd_addr, output wr_hit, output rd_data, output rd_hit);
endinterface // sof_reg_if

// >>> sof_axil.sv
// axi4-lite slave front end for the supervisor registers
`timescale 1ns/100ps
module sof_axil (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             awvalid,
   output logic                  awready,
   input  wire sof_pkg::sof_addr_t awaddr,
   input  wire logic             wvalid,
   output logic                  wready,
   input  wire sof_pkg::sof_word_t wdata,
   input  wire logic [3:0]       wstrb,
   output logic                  bvalid,
   input  wire logic             bready,
   output logic [1:0]            bresp,
   input  wire logic             arvalid,
   output logic                  arready,
   input  wire sof_pkg::sof_addr_t araddr,
   output logic                  rvalid,
   input  wire logic             rready,
   output sof_pkg::sof_word_t    rdata,
   output logic [1:0]            rresp,
   sof_reg_if.bus                rif
);
   import sof_pkg::*;
`include "sof_map.svh"

   logic       aw_full_q, aw_full_d, w_full_q, w_full_d;
   logic       bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic       awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   sof_addr_t  awaddr_q, awaddr_d;
   sof_word_t  wdata_q, wdata_d, rdata_q, rdata_d;
   logic [3:0] wstrb_q, wstrb_d;

   // write fires once both halves are held and no response is pending
   assign rif.wr_en   = aw_full_q & w_full_q & ~bvalid_q;
   assign rif.wr_addr = awaddr_q;
   assign rif.wr_data = wdata_q;
   assign rif.wr_strb = wstrb_q;
   assign rif.rd_addr = araddr;

   always_comb begin
      aw_full_d = aw_full_q;
      w_full_d  = w_full_q;
      awaddr_d  = awaddr_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      rvalid_d  = rvalid_q;
      rresp_d   = rresp_q;
      rdata_d   = rdata_q;
      if (awvalid && awready_q) begin
         aw_full_d = 1'b1;
         awaddr_d  = awaddr;
      end
      if (wvalid && wready_q) begin
         w_full_d = 1'b1;
         wdata_d  = wdata;
         wstrb_d  = wstrb;
      end
      if (rif.wr_en) begin
         aw_full_d = 1'b0;
         w_full_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = rif.wr_hit ? `SOF_RESP_OKAY : `SOF_RESP_SLVERR;
      end
      if (bvalid_q && bready) begin
         bvalid_d = 1'b0;
      end
      if (rvalid_q && rready) begin
         rvalid_d = 1'b0;
      end
      if (arvalid && arready_q) begin
         rvalid_d = 1'b1;
         rdata_d  = rif.rd_hit ? rif.rd_data : '0;
         rresp_d  = rif.rd_hit ? `SOF_RESP_OKAY : `SOF_RESP_SLVERR;
      end
      awready_d = ~aw_full_d & ~bvalid_d;
      wready_d  = ~w_full_d & ~bvalid_d;
      arready_d = ~rvalid_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         awaddr_q  <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `SOF_RESP_OKAY;
         rvalid_q  <= 1'b0;
         rresp_q   <= `SOF_RESP_OKAY;
         rdata_q   <= '0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         arready_q <= 1'b0;
      end else begin
         aw_full_q <= aw_full_d;
         w_full_q  <= w_full_d;
         awaddr_q  <= awaddr_d;
         wdata_q   <= wdata_d;
         wstrb_q   <= wstrb_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         rvalid_q  <= rvalid_d;
         rresp_q   <= rresp_d;
         rdata_q   <= rdata_d;
         awready_q <= awready_d;
         wready_q  <= wready_d;
         arready_q <= arready_d;
      end
   end

   assign awready = awready_q;
   assign wready  = wready_q;
   assign arready = arready_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign rvalid  = rvalid_q;
   assign rresp   = rresp_q;
   assign rdata   = rdata_q;
endmodule // sof_axil

// >>> sof_supervisor.sv
// output fault supervisor: fault latches, serious error state, registers
`timescale 1ns/100ps
module sof_supervisor (
   input  wire logic               aclk,
   input  wire logic               aresetn,
   // axi4-lite register port
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire sof_pkg::sof_addr_t s_axi_awaddr,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   input  wire sof_pkg::sof_word_t s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   output logic [1:0]              s_axi_bresp,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   input  wire sof_pkg::sof_addr_t s_axi_araddr,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   output sof_pkg::sof_word_t      s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   // output stage sensing
   input  wire sof_pkg::sof_chan_t safe_sense,
   input  wire sof_pkg::sof_chan_t safe_overcurrent,
   input  wire sof_pkg::sof_chan_t safe_pulse_err,
   input  wire sof_pkg::sof_chan_t test_overload,
   input  wire logic               supply_low,
   input  wire logic               supply_high,
   input  wire logic               internal_err,
   input  wire logic               cap_transient,
   // drives toward the loads and the application logic
   output sof_pkg::sof_chan_t      safe_out,
   output sof_pkg::sof_chan_t      test_out,
   output logic                    output_aux_supply_en,
   output logic                    app_run,
   output logic [7:0]              app_pdata,
   output logic [11:0]             app_status,
   output logic                    irq
);
   import sof_pkg::*;
`include "sof_map.svh"

   sof_reg_if rif ();

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   sof_axil u_axil (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awvalid (s_axi_awvalid),
      .awready (s_axi_awready),
      .awaddr  (s_axi_awaddr),
      .wvalid  (s_axi_wvalid),
      .wready  (s_axi_wready),
      .wdata   (s_axi_wdata),
      .wstrb   (s_axi_wstrb),
      .bvalid  (s_axi_bvalid),
      .bready  (s_axi_bready),
      .bresp   (s_axi_bresp),
      .arvalid (s_axi_arvalid),
      .arready (s_axi_arready),
      .araddr  (s_axi_araddr),
      .rvalid  (s_axi_rvalid),
      .rready  (s_axi_rready),
      .rdata   (s_axi_rdata),
      .rresp   (s_axi_rresp),
      .rif     (rif.bus)
   );

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   sof_mode_t  mode_q, mode_d;
   logic [7:0] pdata_q, pdata_d;
   sof_chan_t  ovc_q, ovc_d;
   sof_chan_t  tp_q, tp_d;
   logic       high_q, high_d;
   sof_ev_t    ev_q, ev_d;
   sof_ev_t    mask_q, mask_d;
   logic [1:0] cause_q, cause_d;
   logic       sup_low_q;
   sof_chan_t  safe_out_q, safe_out_d;
   sof_chan_t  test_out_q, test_out_d;
   logic       aux_en_q, aux_en_d;
   logic       run_q, run_d;
   logic [7:0] app_pd_q, app_pd_d;
   logic [11:0] app_st_q, app_st_d;
   logic       irq_q, irq_d;

   logic        wr_ctrl, wr_pdata, wr_istat, wr_mask, sw_reset;
   logic        int_fault;
   sof_chan_t   safe_pd, ovc_set, tp_set;
   logic        high_set, all_pd_low;
   logic [11:0] status_word;
   sof_ev_t     ev_set;

   assign safe_pd  = pdata_q[3:0];
   assign wr_ctrl  = rif.wr_en && rif.wr_addr == `SOF_OFS_CTRL && rif.wr_strb[0];
   assign wr_pdata = rif.wr_en && rif.wr_addr == `SOF_OFS_PDATA && rif.wr_strb[0];
   assign wr_istat = rif.wr_en && rif.wr_addr == `SOF_OFS_IRQ_STAT && rif.wr_strb[0];
   assign wr_mask  = rif.wr_en && rif.wr_addr == `SOF_OFS_IRQ_MASK && rif.wr_strb[0];
   assign sw_reset = wr_ctrl && rif.wr_data[`SOF_CTRL_SWRST];

   // a capacitive glitch is lumped in with internal errors on purpose
   assign int_fault = internal_err | cap_transient;

   // ----------------------------------------------------------------
   // fault detection
   // ----------------------------------------------------------------
   assign ovc_set    = safe_overcurrent & safe_out_q;
   assign tp_set     = safe_pulse_err & safe_out_q;
   assign high_set   = |(safe_sense & ~safe_out_q & ~ovc_q);
   assign all_pd_low = (safe_pd == 4'h0) && (safe_sense == 4'h0);

   assign ev_set = {supply_low & ~sup_low_q, int_fault & (mode_q == SOF_RUN),
                    |tp_set, high_set, |ovc_set};

   // status word: short-to-low ok, short-to-high ok, then module bits
   assign status_word = {mode_q == SOF_SERIOUS,
                         ~(|ovc_q) & ~high_q & ~supply_low,
                         ~supply_low & ~supply_high,
                         mode_q == SOF_RUN && ~supply_high,
                         ~tp_q, ~ovc_q};

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      mode_d  = mode_q;
      pdata_d = pdata_q;
      ovc_d   = ovc_q;
      tp_d    = tp_q;
      high_d  = high_q;
      mask_d  = mask_q;
      cause_d = cause_q;
      ev_d    = ev_q;
      if (wr_mask) begin
         mask_d = rif.wr_data[4:0];
      end
      if (wr_istat) begin
         ev_d = ev_d & ~rif.wr_data[4:0];
      end
      ev_d = ev_d | ev_set;
      if (wr_pdata) begin
         pdata_d = rif.wr_data[7:0];
      end
      // clear conditions first so that a fresh set in the same cycle wins
      for (int i = 0; i < 4; i++) begin
         if (!safe_pd[i]) begin
            ovc_d[i] = 1'b0;
         end
         if (all_pd_low) begin
            tp_d[i] = 1'b0;
         end
      end
      if (all_pd_low) begin
         high_d = 1'b0;
      end
      ovc_d  = ovc_d | ovc_set;
      tp_d   = tp_d | tp_set;
      high_d = high_d | high_set;
      case (mode_q)
         SOF_RUN: begin
            if (int_fault) begin
               mode_d  = SOF_SERIOUS;
               cause_d = {cap_transient, internal_err};
            end
         end
         SOF_SERIOUS: begin
            if (sw_reset && !int_fault) begin
               mode_d  = SOF_RUN;
               pdata_d = `SOF_RST_PDATA;
               ovc_d   = '0;
               tp_d    = '0;
               high_d  = 1'b0;
            end
         end
         default: begin
            mode_d = SOF_SERIOUS;
         end
      endcase

      // drive stage, all registered so the pins never glitch
      for (int i = 0; i < 4; i++) begin
         safe_out_d[i] = mode_d == SOF_RUN && pdata_d[i] && !ovc_d[i]
                         && !high_d && !supply_low;
         test_out_d[i] = mode_d == SOF_RUN && pdata_d[4 + i]
                         && !test_overload[i];
      end
      aux_en_d = !high_d && mode_d == SOF_RUN;
      run_d    = mode_d == SOF_RUN && !sw_reset;
      app_pd_d = (mode_d == SOF_RUN) ? pdata_d : 8'h00;
      app_st_d = (mode_d == SOF_RUN) ? status_word : 12'h000;
      irq_d    = |(ev_d & mask_d);
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_q     <= SOF_RUN;
         pdata_q    <= `SOF_RST_PDATA;
         ovc_q      <= '0;
         tp_q       <= '0;
         high_q     <= 1'b0;
         ev_q       <= '0;
         mask_q     <= `SOF_RST_MASK;
         cause_q    <= 2'h0;
         sup_low_q  <= 1'b0;
         safe_out_q <= '0;
         test_out_q <= '0;
         aux_en_q   <= 1'b0;
         run_q      <= 1'b0;
         app_pd_q   <= 8'h00;
         app_st_q   <= 12'h000;
         irq_q      <= 1'b0;
      end else begin
         mode_q     <= mode_d;
         pdata_q    <= pdata_d;
         ovc_q      <= ovc_d;
         tp_q       <= tp_d;
         high_q     <= high_d;
         ev_q       <= ev_d;
         mask_q     <= mask_d;
         cause_q    <= cause_d;
         sup_low_q  <= supply_low;
         safe_out_q <= safe_out_d;
         test_out_q <= test_out_d;
         aux_en_q   <= aux_en_d;
         run_q      <= run_d;
         app_pd_q   <= app_pd_d;
         app_st_q   <= app_st_d;
         irq_q      <= irq_d;
      end
   end

   // ----------------------------------------------------------------
   // register read and decode
   // ----------------------------------------------------------------
   always_comb begin
      rif.rd_data = 32'h0000_0000;
      rif.rd_hit  = 1'b1;
      case (rif.rd_addr)
         `SOF_OFS_CTRL:     rif.rd_data = 32'h0000_0000;
         `SOF_OFS_PDATA:    rif.rd_data = {24'h0, pdata_q};
         `SOF_OFS_STATUS:   rif.rd_data = {20'h0, status_word};
         `SOF_OFS_IRQ_STAT: rif.rd_data = {27'h0, ev_q};
         `SOF_OFS_IRQ_MASK: rif.rd_data = {27'h0, mask_q};
         // limited diagnostics stay readable in the serious state
         `SOF_OFS_DIAG:     rif.rd_data = {29'h0, mode_q == SOF_SERIOUS, cause_q};
         default:           rif.rd_hit  = 1'b0;
      endcase
   end

   always_comb begin
      case (rif.wr_addr)
         `SOF_OFS_CTRL, `SOF_OFS_PDATA, `SOF_OFS_STATUS,
         `SOF_OFS_IRQ_STAT, `SOF_OFS_IRQ_MASK, `SOF_OFS_DIAG: rif.wr_hit = 1'b1;
         default: rif.wr_hit = 1'b0;
      endcase
   end

   assign safe_out             = safe_out_q;
   assign test_out             = test_out_q;
   assign output_aux_supply_en = aux_en_q;
   assign app_run              = run_q;
   assign app_pdata            = app_pd_q;
   assign app_status           = app_st_q;
   assign irq                  = irq_q;
endmodule // sof_supervisor

// >>> sof_supervisor_properties.sv
// port checks of the output fault supervisor
`timescale 1ns/100ps
module sof_supervisor_properties (
   input wire logic               aclk,
   input wire logic               aresetn,
   input wire logic               s_axi_awvalid,
   input wire logic               s_axi_wvalid,
   input wire sof_pkg::sof_chan_t safe_sense,
   input wire sof_pkg::sof_chan_t safe_overcurrent,
   input wire sof_pkg::sof_chan_t safe_pulse_err,
   input wire sof_pkg::sof_chan_t test_overload,
   input wire logic               internal_err,
   input wire logic               cap_transient,
   input wire sof_pkg::sof_chan_t safe_out,
   input wire sof_pkg::sof_chan_t test_out,
   input wire logic               output_aux_supply_en,
   input wire logic               app_run,
   input wire logic [7:0]         app_pdata,
   input wire logic [11:0]        app_status
);
   // ----------------------------------------------------------
   // helper state
   // ----------------------------------------------------------
   logic [1:0] up_q, up_d, busy_q, busy_d;
   // a write still in flight may legally end the serious state
   always_comb begin
      up_d = !aresetn ? 2'h0 : ((up_q == 2'h3) ? up_q : up_q + 2'h1);
      busy_d = {busy_q[0], s_axi_awvalid | s_axi_wvalid};
   end
   always_ff @(posedge aclk) begin
      up_q <= up_d;
      busy_q <= busy_d;
   end
   // ----------------------------------------------------------
   // properties
   // ----------------------------------------------------------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_quiet;
      safe_out == 0 && test_out == 0 && app_pdata == 0 && app_status == 0 && !app_run;
   endsequence
   sequence s_held;
      up_q == 2'h3 && !app_run && app_status == 0 && !s_axi_awvalid && !s_axi_wvalid
      && busy_q == 2'h0;
   endsequence
   a_int_enters:
   assert property (internal_err |-> ##[1:2] (!app_run && !app_status[8]))
      else $error("no serious entry");
   a_cap_enters:
   assert property (cap_transient |-> ##[1:2] !app_run)
      else $error("transient not fatal");
   a_serious_quiet:
   assert property (internal_err |-> ##2 s_quiet [*4])
      else $error("serious not quiet");
   a_serious_held:
   assert property (s_held |=> (!app_run && app_status == 0))
      else $error("serious left early");
   a_high_cuts:
   assert property (up_q == 2'h3 && app_run && (safe_sense & ~safe_out) != 0
      |-> ##[1:2] (!output_aux_supply_en && safe_out == 0 && !app_status[10]))
      else $error("supply not cut");
   a_ovc_off:
   assert property (up_q == 2'h3 && app_run && safe_overcurrent[0] && safe_out[0]
      |-> ##[1:2] (!safe_out[0] && !app_status[0] && !app_status[10]))
      else $error("overcurrent not off");
   a_pulse_flag:
   assert property (up_q == 2'h3 && app_run && safe_pulse_err[0] && safe_out[0]
      |-> ##[1:2] !app_status[4])
      else $error("test pulse fault not flagged");
   a_thermal_off:
   assert property (app_run && test_overload[0] |-> ##[1:2] !test_out[0])
      else $error("test output left on");
endmodule // sof_supervisor_properties

bind sof_supervisor sof_supervisor_properties u_props (.aclk, .aresetn,
   .s_axi_awvalid, .s_axi_wvalid, .safe_sense, .safe_overcurrent, .safe_pulse_err,
   .test_overload, .internal_err, .cap_transient, .safe_out, .test_out,
   .output_aux_supply_en, .app_run, .app_pdata, .app_status);

// >>> sof_load_model.sv
// behavioural loads and wiring on the supervisor output terminals
`timescale 1ns/100ps
module sof_load_model (
   input  wire sof_pkg::sof_chan_t safe_out,
   input  wire logic               output_aux_supply_en,
   input  wire sof_pkg::sof_chan_t stuck_high,
   input  wire sof_pkg::sof_chan_t short_low,
   input  wire sof_pkg::sof_chan_t pulse_bad,
   input  wire sof_pkg::sof_chan_t hot_load,
   output sof_pkg::sof_chan_t      safe_sense,
   output sof_pkg::sof_chan_t      safe_overcurrent,
   output sof_pkg::sof_chan_t      safe_pulse_err,
   output sof_pkg::sof_chan_t      test_overload
);
   // a wire shorted to 24 v stays high even with the supply cut
   assign safe_sense = (safe_out & {4{output_aux_supply_en}} & ~short_low) | stuck_high;
   assign safe_overcurrent = safe_out & short_low;
   assign safe_pulse_err = safe_out & pulse_bad;
   // overload held as a load condition, so thermal cut does not oscillate
   assign test_overload = hot_load;
endmodule // sof_load_model

// >>> sof_supervisor_test.sv
// self-checking bench for the output fault supervisor
`timescale 1ns/100ps
`include "sof_map.svh"
module sof_supervisor_test;
   import sof_pkg::*;
   logic       aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic       awready, wready, bvalid, arready, rvalid, aux_en, app_run, irq;
   logic       supply_low, supply_high, internal_err, cap_transient;
   logic [1:0] bresp, rresp, rs;
   sof_addr_t  awaddr, araddr;
   sof_word_t  wdata, rdata, rd;
   sof_chan_t  sense, ovc, perr, tovl, safe_out, test_out, stuck, shortl, pbad, hot;
   logic [7:0] app_pdata;
   logic [11:0] app_status;
   int         bad_count = 0;
   int         checked = 0;

   sof_supervisor uut (.aclk, .aresetn,
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .safe_sense(sense),
      .safe_overcurrent(ovc), .safe_pulse_err(perr), .test_overload(tovl),
      .supply_low, .supply_high, .internal_err, .cap_transient, .safe_out, .test_out,
      .output_aux_supply_en(aux_en), .app_run, .app_pdata, .app_status, .irq);
   sof_load_model u_load (.safe_out, .output_aux_supply_en(aux_en),
      .stuck_high(stuck), .short_low(shortl), .pulse_bad(pbad), .hot_load(hot),
      .safe_sense(sense), .safe_overcurrent(ovc), .safe_pulse_err(perr),
      .test_overload(tovl));

   // ----------------------------------------------------------
   // checking and bus tasks
   // ----------------------------------------------------------
   task automatic conclude;
      $display("checked %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic cmp_word(input sof_word_t got, input sof_word_t exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: response %h expected %h", $time, got, exp);
      end
   endtask
   task automatic hang;
      bad_count++;
      $display("Error at %0t: bus never answered", $time);
      conclude();
   endtask
   task automatic wr(input sof_addr_t a, input sof_word_t d, output logic [1:0] r);
      int n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         n++;
         if (n > 40) hang();
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rdr(input sof_addr_t a, output sof_word_t d, output logic [1:0] r);
      int n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         n++;
         if (n > 40) hang();
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic settle;
      repeat (3) @(posedge aclk);
   endtask
   task automatic pd(input logic [7:0] v);
      wr(`SOF_OFS_PDATA, {24'h0, v}, rs);
      settle();
   endtask
   task automatic see(input logic [3:0] so, input logic ax, input logic [11:0] m, st);
      cmp_word(safe_out, so);
      cmp_word(aux_en, ax);
      cmp_word(app_status & m, st);
   endtask
   task automatic pulse_err_in(input logic cap);
      {cap_transient, internal_err} <= {cap, !cap};
      @(posedge aclk);
      {cap_transient, internal_err} <= 2'h0;
      settle();
   endtask

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {supply_low, supply_high, internal_err, cap_transient} = 4'h0;
      {awaddr, araddr, wdata} = 48'h0;
      {stuck, shortl, pbad, hot} = 16'h0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      settle();
      rdr(`SOF_OFS_STATUS, rd, rs);
      cmp_word(rd, 32'h7ff);
      rdr(8'h20, rd, rs);
      cmp_resp(rs, `SOF_RESP_SLVERR);
      $display("test 1 done");
      pd(8'h0f);
      shortl <= 4'h1;
      settle();
      see(4'he, 1'b1, 12'hfff, 12'h3fe);
      shortl <= 4'h0;
      settle();
      see(4'he, 1'b1, 12'hfff, 12'h3fe);
      pd(8'h0e);
      pd(8'h0f);
      see(4'hf, 1'b1, 12'hfff, 12'h7ff);
      cmp_word(irq, 1'b0);
      wr(`SOF_OFS_IRQ_MASK, 32'h1, rs);
      settle();
      cmp_word(irq, 1'b1);
      wr(`SOF_OFS_IRQ_STAT, 32'h1, rs);
      settle();
      cmp_word(irq, 1'b0);
      $display("test 2 done");
      pd(8'h01);
      stuck <= 4'h4;
      settle();
      see(4'h0, 1'b0, 12'h400, 12'h000);
      pd(8'h00);
      see(4'h0, 1'b0, 12'h400, 12'h000);
      pd(8'h02);
      stuck <= 4'h0;
      settle();
      see(4'h0, 1'b0, 12'h400, 12'h000);
      pd(8'h00);
      see(4'h0, 1'b1, 12'hfff, 12'h7ff);
      $display("test 3 done");
      pd(8'h01);
      pbad <= 4'h1;
      settle();
      see(4'h1, 1'b1, 12'hfff, 12'h7ef);
      pbad <= 4'h0;
      pd(8'h00);
      see(4'h0, 1'b1, 12'hfff, 12'h7ff);
      $display("test 4 done");
      wr(`SOF_OFS_IRQ_STAT, 32'h1f, rs);
      pd(8'h10);
      hot <= 4'h1;
      settle();
      cmp_word(test_out, 4'h0);
      cmp_word(app_status, 12'h7ff);
      rdr(`SOF_OFS_IRQ_STAT, rd, rs);
      cmp_word(rd, 32'h0);
      hot <= 4'h0;
      settle();
      cmp_word(test_out, 4'h1);
      $display("test 5 done");
      pd(8'h13);
      pulse_err_in(1'b0);
      cmp_word(app_run, 1'b0);
      cmp_word(safe_out, 4'h0);
      cmp_word({test_out, app_pdata}, 12'h0);
      cmp_word(app_status, 12'h0);
      rdr(`SOF_OFS_STATUS, rd, rs);
      cmp_word(rd & 32'h900, 32'h800);
      rdr(`SOF_OFS_DIAG, rd, rs);
      cmp_word(rd & 32'h5, 32'h5);
      repeat (20) @(posedge aclk);
      cmp_word(app_run, 1'b0);
      wr(`SOF_OFS_CTRL, 32'h1, rs);
      settle();
      cmp_word({app_run, app_status}, 13'h17ff);
      cmp_word(app_pdata, 8'h0);
      pulse_err_in(1'b1);
      cmp_word(app_run, 1'b0);
      rdr(`SOF_OFS_DIAG, rd, rs);
      cmp_word(rd & 32'h6, 32'h6);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      settle();
      cmp_word({app_run, app_status}, 13'h17ff);
      $display("test 6 done");
      conclude();
   end
endmodule // sof_supervisor_test
